// file: bus_status_consts.svh
`ifndef BUS_STATUS_CONSTS_SVH
`define BUS_STATUS_CONSTS_SVH

// Register offsets on the peripheral register port
`define OFS_PRIMARY_ADDR 16'h3070
`define OFS_CONTROL_ONE 16'h3072
`define OFS_STATUS 16'h3073
`define OFS_DATA 16'h3074
`define OFS_ENABLES 16'h3075
`define OFS_SECOND_ADDR 16'h3076
`define OFS_UPPER_WINDOW 16'h3077

// Status register field positions
`define BIT_BYTE_DONE 7
`define BIT_SLAVE_ADDRESSED 6
`define BIT_BUS_BUSY 5
`define BIT_ARB_LOST 4
`define BIT_WINDOW_HIT 3
`define BIT_SLAVE_DIR 2

// Control one field position
`define BIT_TX_SELECT 4

// Enables register field positions
`define BIT_GENERAL_CALL_EN 0
`define BIT_SECOND_ADDR_EN 1
`define BIT_ALERT_EN 2
`define BIT_WINDOW_EN 3

// Reserved two-wire addresses (7-bit)
`define GENERAL_CALL_ADDR 7'h00
`define ALERT_RESPONSE_ADDR 7'h0c

// Reset values
`define RESET_BYTE 8'h00
`define RESET_STATUS 8'h00

`endif

// file: bus_status_flags.sv
`timescale 1ns/1ps
`include "bus_status_consts.svh"
module bus_status_flags
    import bus_status_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire reg_addr_t reg_addr,
    input wire byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output byte_t reg_rdata,
    // Two-wire bus lines, asynchronous
    input wire logic scl_in,
    input wire logic sda_in,
    // Events from the byte shifter
    input wire logic byte_done,
    input wire logic arb_lost,
    input wire logic addr_valid,
    input wire byte_t addr_byte,
    input wire byte_t rx_data,
    // To the byte shifter
    output logic addr_match,
    output byte_t tx_data,
    output logic tx_load,
    output logic tx_select
);

    // Software registers
    byte_t primary_slave_address;
    byte_t upper_window_address;
    byte_t second_address;
    byte_t enables;
    byte_t control_one_register;

    // Status flags
    logic byte_done_flag;
    logic slave_addressed_flag;
    logic bus_busy_flag;
    logic arbitration_lost_flag;
    logic window_hit_flag;
    logic slave_direction_flag;

    // Synchronised bus lines
    logic scl_q1;
    logic scl_q2;
    logic sda_q1;
    logic sda_q2;
    logic sda_q3;
    logic start_det;
    logic stop_det;

    // Decoded accesses
    logic wr_control;
    logic wr_status;
    logic wr_data;
    logic rd_data;

    // Address compare terms
    bus_addr_t call_addr;
    logic general_call_enable;
    logic second_address_enable;
    logic smbus_alert_response_enable;
    logic window_match_enable;
    logic hit_primary;
    logic hit_upper;
    logic hit_second;
    logic hit_general;
    logic hit_alert;
    logic hit_window;
    logic next_window_hit;

    // Address compare against a stored register, address in bits 7:1
    function automatic logic addr_eq(input bus_addr_t a, input byte_t r);
        addr_eq = (a == r[7:1]);
    endfunction : addr_eq

    // Write decode for one register offset
    function automatic logic wr_hit(input reg_addr_t a,
                                    input reg_addr_t ofs,
                                    input logic wr);
        wr_hit = wr && (a == ofs);
    endfunction : wr_hit

    // Access decode
    assign wr_control = wr_hit(reg_addr, `OFS_CONTROL_ONE, reg_wr);
    assign wr_status = wr_hit(reg_addr, `OFS_STATUS, reg_wr);
    assign wr_data = wr_hit(reg_addr, `OFS_DATA, reg_wr);
    assign rd_data = reg_rd && (reg_addr == `OFS_DATA);
    assign tx_select = control_one_register[`BIT_TX_SELECT];

    // Enable bits
    assign general_call_enable = enables[`BIT_GENERAL_CALL_EN];
    assign second_address_enable = enables[`BIT_SECOND_ADDR_EN];
    assign smbus_alert_response_enable = enables[`BIT_ALERT_EN];
    assign window_match_enable = enables[`BIT_WINDOW_EN];

    // Address match sources
    assign call_addr = addr_byte[7:1];
    assign hit_primary = addr_eq(call_addr, primary_slave_address);
    assign hit_upper = addr_eq(call_addr, upper_window_address) &&
        (upper_window_address[7:1] != 7'h00) &&
        (call_addr != 7'h00);
    assign hit_second = second_address_enable &&
        addr_eq(call_addr, second_address);
    assign hit_general = general_call_enable &&
        (call_addr == `GENERAL_CALL_ADDR);
    assign hit_alert = smbus_alert_response_enable &&
        (call_addr == `ALERT_RESPONSE_ADDR);
    assign hit_window = window_match_enable &&
        (call_addr >= primary_slave_address[7:1]) &&
        (call_addr <= upper_window_address[7:1]);
    assign next_window_hit = hit_upper || hit_window;

    // Match reported to the shifter in the address-byte cycle
    assign addr_match = addr_valid && (hit_primary || hit_upper ||
        hit_second || hit_general || hit_alert || hit_window);

    // Configuration registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            primary_slave_address <= `RESET_BYTE;
            upper_window_address <= `RESET_BYTE;
            second_address <= `RESET_BYTE;
            enables <= `RESET_BYTE;
            control_one_register <= `RESET_BYTE;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `OFS_PRIMARY_ADDR: primary_slave_address <= reg_wdata;
                `OFS_UPPER_WINDOW: upper_window_address <= reg_wdata;
                `OFS_SECOND_ADDR: second_address <= reg_wdata;
                `OFS_ENABLES: enables <= {4'h0, reg_wdata[3:0]};
                `OFS_CONTROL_ONE: control_one_register <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Transmit data latch and load pulse
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_data <= `RESET_BYTE;
            tx_load <= 1'b0;
        end else begin
            tx_load <= wr_data;
            if (wr_data) begin
                tx_data <= reg_wdata;
            end
        end
    end

    // Two-flop synchronisers and history for edge detection
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            scl_q1 <= 1'b1;
            scl_q2 <= 1'b1;
            sda_q1 <= 1'b1;
            sda_q2 <= 1'b1;
            sda_q3 <= 1'b1;
        end else begin
            scl_q1 <= scl_in;
            scl_q2 <= scl_q1;
            sda_q1 <= sda_in;
            sda_q2 <= sda_q1;
            sda_q3 <= sda_q2;
        end
    end

    // Data falls with clock high is START, rises with clock high is STOP
    assign start_det = scl_q2 && sda_q3 && !sda_q2;
    assign stop_det = scl_q2 && !sda_q3 && sda_q2;

    // Bus busy tracking
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_busy_flag <= 1'b0;
        end else if (start_det) begin
            bus_busy_flag <= 1'b1;
        end else if (stop_det) begin
            bus_busy_flag <= 1'b0;
        end
    end

    // Byte done flag, a completing byte wins over a clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            byte_done_flag <= 1'b0;
        end else if (byte_done) begin
            byte_done_flag <= 1'b1;
        end else if ((rd_data && !tx_select) || (wr_data && tx_select)) begin
            byte_done_flag <= 1'b0;
        end
    end

    // Slave addressed flag and direction bit
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            slave_addressed_flag <= 1'b0;
            slave_direction_flag <= 1'b0;
        end else if (addr_match) begin
            slave_addressed_flag <= 1'b1;
            slave_direction_flag <= addr_byte[0];
        end else if (wr_control) begin
            slave_addressed_flag <= 1'b0;
        end
    end

    // Window hit flag
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            window_hit_flag <= 1'b0;
        end else if (addr_valid && next_window_hit) begin
            window_hit_flag <= 1'b1;
        end else if (wr_control) begin
            window_hit_flag <= 1'b0;
        end
    end

    // Arbitration lost flag, write one to clear, loss wins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            arbitration_lost_flag <= 1'b0;
        end else if (arb_lost) begin
            arbitration_lost_flag <= 1'b1;
        end else if (wr_status && reg_wdata[`BIT_ARB_LOST]) begin
            arbitration_lost_flag <= 1'b0;
        end
    end

    // Read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= `RESET_BYTE;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `OFS_PRIMARY_ADDR: reg_rdata <= primary_slave_address;
                `OFS_UPPER_WINDOW: reg_rdata <= upper_window_address;
                `OFS_SECOND_ADDR: reg_rdata <= second_address;
                `OFS_ENABLES: reg_rdata <= enables;
                `OFS_CONTROL_ONE: reg_rdata <= control_one_register;
                `OFS_DATA: reg_rdata <= rx_data;
                `OFS_STATUS: reg_rdata <= {byte_done_flag,
                    slave_addressed_flag, bus_busy_flag,
                    arbitration_lost_flag, window_hit_flag,
                    slave_direction_flag, 2'b00};
                default: reg_rdata <= `RESET_BYTE;
            endcase
        end else begin
            reg_rdata <= `RESET_BYTE;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_byte_done_set: assert property (
        byte_done |=> byte_done_flag)
        else $error("byte done flag not set");

    a_byte_done_rx: assert property (
        rd_data && !tx_select && !byte_done |=> !byte_done_flag)
        else $error("byte done not cleared by receive read");

    a_byte_done_tx: assert property (
        wr_data && tx_select && !byte_done |=> !byte_done_flag)
        else $error("byte done not cleared by transmit write");

    a_primary_match: assert property (
        addr_valid && hit_primary |=> slave_addressed_flag &&
            slave_direction_flag == $past(addr_byte[0]))
        else $error("primary match not flagged");

    a_general_call: assert property (
        addr_valid && general_call_enable && call_addr == 7'h00
            |=> slave_addressed_flag)
        else $error("general call not flagged");

    a_second_addr: assert property (
        addr_valid && second_address_enable &&
            call_addr == second_address[7:1] |=> slave_addressed_flag)
        else $error("second address not flagged");

    a_alert_addr: assert property (
        addr_valid && smbus_alert_response_enable &&
            call_addr == 7'h0c |=> slave_addressed_flag)
        else $error("alert response not flagged");

    a_control_clear: assert property (
        wr_control && !addr_match |=> !slave_addressed_flag &&
            !window_hit_flag)
        else $error("control write did not clear address flags");

    a_busy_track: assert property (
        (start_det |=> bus_busy_flag) and
            (bus_busy_flag && !stop_det |=> bus_busy_flag))
        else $error("busy not set on start");

    a_busy_stop: assert property (
        stop_det && !start_det |=> !bus_busy_flag)
        else $error("busy not cleared on stop");

    a_arb_w1c: assert property (
        wr_status && reg_wdata[4] && !arb_lost |=> !arbitration_lost_flag)
        else $error("arbitration lost not cleared by one");

    a_arb_hold: assert property (
        arbitration_lost_flag && !(wr_status && reg_wdata[4])
            |=> arbitration_lost_flag)
        else $error("arbitration lost dropped without a clear");

    a_window_hit: assert property (
        addr_valid && window_match_enable &&
            call_addr >= primary_slave_address[7:1] &&
            call_addr <= upper_window_address[7:1]
            |=> window_hit_flag && slave_addressed_flag)
        else $error("window match not flagged");

    a_reset_idle: assert property (
        disable iff (1'b0) rst |=> !bus_busy_flag && !byte_done_flag &&
            !slave_addressed_flag && !arbitration_lost_flag)
        else $error("flags not idle after reset");

endmodule : bus_status_flags

// file: bus_status_pkg.sv
package bus_status_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [15:0] reg_addr_t;
    typedef logic [6:0] bus_addr_t;

endpackage : bus_status_pkg

// file: tb_top.sv
`timescale 1ns/1ps
`include "bus_status_consts.svh"
module tb_top;
    import bus_status_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    reg_addr_t reg_addr = 16'h0000;
    byte_t reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic byte_done = 1'b0;
    logic arb_lost = 1'b0;
    logic addr_valid = 1'b0;
    byte_t addr_byte = 8'h00;
    byte_t rx_data = 8'h00;
    byte_t reg_rdata, tx_data;
    logic addr_match, tx_load, tx_select, scl, sda;
    int miscompares = 0;
    int check_count = 0;
    int prim, sec, upper, en, bd, sa, bb, al, wh, dir, txs;
    byte_t tbl [7] = '{8'h43, 8'h66, 8'h00, 8'h19, 8'h80, 8'h61, 8'ha1};

    bus_status_flags bus_status_flags_inst (.sys_clk(sys_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl), .sda_in(sda),
        .byte_done(byte_done), .arb_lost(arb_lost), .addr_valid(addr_valid),
        .addr_byte(addr_byte), .rx_data(rx_data), .addr_match(addr_match),
        .tx_data(tx_data), .tx_load(tx_load), .tx_select(tx_select));
    two_wire_far_side two_wire_far_side_inst (.scl(scl), .sda(sda));

    // Clock, 5 ns period
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Verdict and end of run
    task stop_test;
        if (miscompares == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    // Compare one byte result
    task chk(input byte_t got, input byte_t exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    // Model: window or upper-address hit
    function automatic int hit_win(int a);
        return (upper != 0 && a != 0 && a == upper) ||
            (en[3] && a >= prim && a <= upper);
    endfunction : hit_win

    // Model: any address source hit
    function automatic int hit(int a);
        return a == prim || hit_win(a) || (en[0] && a == 0) ||
            (en[1] && a == sec) || (en[2] && a == 12);
    endfunction : hit

    // Model: expected status byte
    function automatic byte_t status();
        return {bd[0], sa[0], bb[0], al[0], wh[0], dir[0], 2'b00};
    endfunction : status

    // Clear every model register and flag
    task model_reset;
        {prim, sec, upper, en, bd, sa, bb, al, wh, dir, txs} = '0;
    endtask : model_reset

    // One register write, model updated alongside
    task wr(input reg_addr_t a, input byte_t d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        case (a)
            `OFS_PRIMARY_ADDR: prim = d[7:1];
            `OFS_SECOND_ADDR: sec = d[7:1];
            `OFS_UPPER_WINDOW: upper = d[7:1];
            `OFS_ENABLES: en = d[3:0];
            `OFS_CONTROL_ONE: {txs, sa, wh} = {31'h0, d[4], 64'h0};
            `OFS_STATUS: al = d[4] ? 0 : al;
            `OFS_DATA: bd = txs ? 0 : bd;
            default: ;
        endcase
        #1;
        chk({7'h00, tx_select}, {7'h00, txs[0]});
        if (a == `OFS_DATA) begin
            chk({7'h00, tx_load}, 8'h01);
            chk(tx_data, d);
        end
    endtask : wr

    // One register read checked against the model
    task rd_chk(input reg_addr_t a);
        byte_t exp;
        exp = (a == `OFS_STATUS) ? status() :
            (a == `OFS_DATA) ? rx_data : 8'h00;
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
        if (a == `OFS_DATA && txs == 0) begin
            bd = 0;
        end
    endtask : rd_chk

    // One cycle of shifter events
    task ev(input logic b, input logic l, input logic v, input byte_t ab);
        @(posedge sys_clk);
        byte_done <= b;
        arb_lost <= l;
        addr_valid <= v;
        addr_byte <= ab;
        #1;
        if (v) begin
            chk({7'h00, addr_match}, {7'h00, hit(ab[7:1]) != 0});
            if (hit(ab[7:1])) begin
                {sa, dir} = {32'h1, 31'h0, ab[0]};
                wh = hit_win(ab[7:1]) ? 1 : wh;
            end
        end
        bd = b ? 1 : bd;
        al = l ? 1 : al;
        @(posedge sys_clk);
        {byte_done, arb_lost, addr_valid} <= 3'b000;
    endtask : ev

    // Watchdog
    initial begin
        #50000;
        miscompares++;
        stop_test();
    end

    // Main sequence
    initial begin
        void'($urandom(32'ha58c));
        model_reset();
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(`OFS_STATUS);
        rd_chk(16'h3071);
        wr(`OFS_PRIMARY_ADDR, 8'h42);
        wr(`OFS_SECOND_ADDR, 8'h66);
        wr(`OFS_UPPER_WINDOW, 8'h80);
        wr(`OFS_ENABLES, 8'h0f);
        for (int i = 0; i < 19; i++) begin
            if (i == 7) begin
                wr(`OFS_ENABLES, 8'h00);
            end
            ev(0, 0, 1, i < 7 ? tbl[i] : 8'($urandom));
            rd_chk(`OFS_STATUS);
            wr(`OFS_CONTROL_ONE, {3'h0, dir[0], 4'h0});
            rd_chk(`OFS_STATUS);
        end
        @(posedge sys_clk);
        rx_data <= 8'($urandom);
        wr(`OFS_CONTROL_ONE, 8'h00);
        ev(1, 0, 0, 8'h00);
        rd_chk(`OFS_STATUS);
        wr(`OFS_DATA, 8'h5a);
        rd_chk(`OFS_STATUS);
        rd_chk(`OFS_DATA);
        rd_chk(`OFS_STATUS);
        wr(`OFS_CONTROL_ONE, 8'h10);
        ev(1, 0, 0, 8'h00);
        rd_chk(`OFS_DATA);
        rd_chk(`OFS_STATUS);
        wr(`OFS_DATA, 8'ha5);
        rd_chk(`OFS_STATUS);
        ev(0, 1, 0, 8'h00);
        rd_chk(`OFS_STATUS);
        wr(`OFS_STATUS, 8'hef);
        rd_chk(`OFS_STATUS);
        wr(`OFS_STATUS, 8'h10);
        rd_chk(`OFS_STATUS);
        two_wire_far_side_inst.start_cond();
        repeat (5) @(posedge sys_clk);
        bb = 1;
        rd_chk(`OFS_STATUS);
        ev(1, 1, 1, 8'h85);
        two_wire_far_side_inst.stop_cond();
        repeat (5) @(posedge sys_clk);
        bb = 0;
        rd_chk(`OFS_STATUS);
        two_wire_far_side_inst.start_cond();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        model_reset();
        rd_chk(`OFS_STATUS);
        stop_test();
    end
endmodule : tb_top

// file: two_wire_far_side.sv
`timescale 1ns/1ps
module two_wire_far_side (
    // Bus lines toward the device, pulled up while idle
    output logic scl,
    output logic sda
);
    // Lines rest high between frames, clock stands still
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // START: data falls while clock is high, then clock goes low
    task start_cond;
        sda = 1'b0;
        #20 scl = 1'b0;
    endtask : start_cond
    // STOP: clock returns high, then data rises
    task stop_cond;
        #21 scl = 1'b1; // Off the clock edge when called on one
        #20 sda = 1'b1;
    endtask : stop_cond
endmodule : two_wire_far_side
